// ===== rtl/pin_two_output_ctrl.sv
// Purpose: Pin two output control register with source selection and AXI4-Lite access
// Assumes: One clock; all status inputs synchronous to MCLK_IN
// Notes:   Pin level and drive follow the control register one cycle later
//
// Function
// [R1] The control register at index 0x12 resets to zero: pin off, selectors zero.
// [R2] Bits 4:2 pick the group: ports 0-3, device status, or transmit port.
// [R3] For a receive port, select codes 0-3 give that port's forwarded signals 0-3.
// [R4] For a receive port, codes 4-7 give lock, pass, frame valid, line valid.
// [R5] For device status, code 2 gives AND of locks of enabled ports.
// [R6] For device status, code 3 gives AND of passes, code 4 frame sync.
// [R7] For transmit port, codes 0-3 give pass AND, pass OR, frame, line valid.
// [R8] For transmit port, code 4 gives synchronized, code 5 transmit interrupt.
// [R9] Bit 0 enables the pin driver; bit 1 is the locally written value.
// [R10] For device status, code 0 gives local value, code 1 OR of locks.
// [R11] With drive disabled the pin is not driven; reserved codes give low.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module pin_two_output_ctrl (
  input  wire logic                        MCLK_IN,
  input  wire logic                        RESET_IN,
  input  wire logic [7:0]                  AWADDR_IN,
  input  wire logic                        AWVALID_IN,
  output logic                             AWREADY_OUT,
  input  wire logic [31:0]                 WDATA_IN,
  input  wire logic [3:0]                  WSTRB_IN,
  input  wire logic                        WVALID_IN,
  output logic                             WREADY_OUT,
  output logic [1:0]                       BRESP_OUT,
  output logic                             BVALID_OUT,
  input  wire logic                        BREADY_IN,
  input  wire logic [7:0]                  ARADDR_IN,
  input  wire logic                        ARVALID_IN,
  output logic                             ARREADY_OUT,
  output logic [31:0]                      RDATA_OUT,
  output logic [1:0]                       RRESP_OUT,
  output logic                             RVALID_OUT,
  input  wire logic                        RREADY_IN,
  input  wire pin_two_pkg::rx_port_s [3:0] RX_PORTS_IN,
  input  wire logic [3:0]                  RX_ENABLE_IN,
  input  wire logic [3:0]                  TX_SELECT_IN,
  input  wire logic                        FRAME_SYNC_IN,
  input  wire pin_two_pkg::tx_port_s       TX_STATUS_IN,
  output logic                             PIN_TWO_OUT,
  output logic                             PIN_TWO_DRIVE_N_OUT
);

  typedef struct packed {
    pin_two_pkg::ctrl_s ctrl;
    logic               aw_rdy;
    logic [7:0]         aw_addr;
    logic               w_rdy;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               b_vld;
    logic [1:0]         b_resp;
    logic               ar_rdy;
    logic               r_vld;
    logic [1:0]         r_resp;
    logic [31:0]        r_data;
    logic               pin_level;
    logic               pin_drive_n;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic   mux_level;

  function automatic logic is_addr(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  pin_two_source_mux u_mux (
    .ctrl_in       (st_reg.ctrl),
    .rx_ports_in   (RX_PORTS_IN),
    .rx_enable_in  (RX_ENABLE_IN),
    .tx_select_in  (TX_SELECT_IN),
    .frame_sync_in (FRAME_SYNC_IN),
    .tx_in         (TX_STATUS_IN),
    .level_out     (mux_level)
  );

  always_comb begin
    st_next = st_reg;

    // Address and data may arrive in either order; each is held until both are in
    if (AWVALID_IN && st_reg.aw_rdy) begin
      st_next.aw_rdy  = 1'b0;
      st_next.aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && st_reg.w_rdy) begin
      st_next.w_rdy  = 1'b0;
      st_next.w_data = WDATA_IN;
      st_next.w_strb = WSTRB_IN;
    end
    if (!st_reg.aw_rdy && !st_reg.w_rdy && !st_reg.b_vld) begin
      st_next.b_vld = 1'b1;
      if (is_addr(st_reg.aw_addr, pin_two_pkg::CTRL_ADDR)) begin
        st_next.b_resp = pin_two_pkg::RESP_OKAY;
        // Only the low byte lane carries the register; other lanes are ignored
        if (st_reg.w_strb[0]) begin
          st_next.ctrl = pin_two_pkg::ctrl_s'(st_reg.w_data[7:0]); // [R2]
        end
      end else begin
        st_next.b_resp = pin_two_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.b_vld && BREADY_IN) begin
      st_next.b_vld  = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy  = 1'b1;
    end

    // Read: one outstanding at a time, answer one cycle after the address
    if (ARVALID_IN && st_reg.ar_rdy) begin
      st_next.ar_rdy = 1'b0;
      st_next.r_vld  = 1'b1;
      st_next.r_resp = pin_two_pkg::RESP_OKAY;
      st_next.r_data = 32'h0000_0000;
      if (is_addr(ARADDR_IN, pin_two_pkg::CTRL_ADDR)) begin
        st_next.r_data[7:0] = st_reg.ctrl;
      end else if (is_addr(ARADDR_IN, pin_two_pkg::STATUS_ADDR)) begin
        st_next.r_data[pin_two_pkg::STAT_DRIVE_BIT] = !st_reg.pin_drive_n;
        st_next.r_data[pin_two_pkg::STAT_LEVEL_BIT] = st_reg.pin_level;
      end else begin
        st_next.r_resp = pin_two_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.r_vld && RREADY_IN) begin
      st_next.r_vld  = 1'b0;
      st_next.ar_rdy = 1'b1;
    end

    // Pin forced low and released whenever the driver is off
    st_next.pin_drive_n = !st_reg.ctrl.drive_enable; // [R9]
    st_next.pin_level   = st_reg.ctrl.drive_enable & mux_level; // [R11]
  end

  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_reg             <= '0;
      st_reg.ctrl        <= pin_two_pkg::CTRL_RESET; // [R1]
      st_reg.aw_rdy      <= 1'b1;
      st_reg.w_rdy       <= 1'b1;
      st_reg.ar_rdy      <= 1'b1;
      st_reg.pin_drive_n <= 1'b1; // [R1]
    end else begin
      st_reg <= st_next;
    end
  end

  assign AWREADY_OUT         = st_reg.aw_rdy;
  assign WREADY_OUT          = st_reg.w_rdy;
  assign BVALID_OUT          = st_reg.b_vld;
  assign BRESP_OUT           = st_reg.b_resp;
  assign ARREADY_OUT         = st_reg.ar_rdy;
  assign RVALID_OUT          = st_reg.r_vld;
  assign RRESP_OUT           = st_reg.r_resp;
  assign RDATA_OUT           = st_reg.r_data;
  assign PIN_TWO_OUT         = st_reg.pin_level;
  assign PIN_TWO_DRIVE_N_OUT = st_reg.pin_drive_n;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  logic [2:0] src;
  logic [2:0] sel;
  logic       en;
  assign src = st_reg.ctrl.source_group;
  assign sel = st_reg.ctrl.signal_select;
  assign en  = st_reg.ctrl.drive_enable;

  a_reset_state: assert property ( // [R1]
    $past(RESET_IN) |-> (st_reg.ctrl == 8'h00) && PIN_TWO_DRIVE_N_OUT && !PIN_TWO_OUT
  ) else $error("Control or pin not cleared after reset");

  a_ctrl_write: assert property ( // [R9]
    (!st_reg.aw_rdy && !st_reg.w_rdy && !st_reg.b_vld && st_reg.w_strb[0]
      && st_reg.aw_addr == 8'h48)
    |=> (st_reg.ctrl == $past(st_reg.w_data[7:0])) ##1 (PIN_TWO_DRIVE_N_OUT == !$past(st_reg.w_data[0], 2))
  ) else $error("Control write did not reach the pin driver");

  a_drive_off: assert property ( // [R11]
    !en |=> PIN_TWO_DRIVE_N_OUT && !PIN_TWO_OUT
  ) else $error("Pin driven while drive is disabled");

  a_rx_forward: assert property ( // [R3]
    en && !src[2] && !sel[2]
    |=> !PIN_TWO_DRIVE_N_OUT && PIN_TWO_OUT == $past(RX_PORTS_IN[src[1:0]].gpio[sel[1:0]])
  ) else $error("Forwarded signal not on pin");

  a_rx_lock: assert property ( // [R4]
    en && !src[2] && sel == 3'h4 |=> PIN_TWO_OUT == $past(RX_PORTS_IN[src[1:0]].lock)
  ) else $error("Port lock not on pin");

  a_rx_line: assert property ( // [R4]
    en && !src[2] && sel == 3'h7 |=> PIN_TWO_OUT == $past(RX_PORTS_IN[src[1:0]].line_valid)
  ) else $error("Port line valid not on pin");

  a_dev_lock_and: assert property ( // [R5]
    en && src == 3'h4 && sel == 3'h2
    |=> PIN_TWO_OUT == $past(&({RX_PORTS_IN[3].lock, RX_PORTS_IN[2].lock,
                                RX_PORTS_IN[1].lock, RX_PORTS_IN[0].lock} | ~RX_ENABLE_IN))
  ) else $error("Lock AND of enabled ports wrong");

  a_dev_sync: assert property ( // [R6]
    en && src == 3'h4 && sel == 3'h4 |=> PIN_TWO_OUT == $past(FRAME_SYNC_IN)
  ) else $error("Frame sync not on pin");

  a_dev_local: assert property ( // [R10]
    en && src == 3'h4 && sel == 3'h0 |=> PIN_TWO_OUT == $past(st_reg.ctrl.local_value)
  ) else $error("Local value not on pin");

  a_tx_pass_or: assert property ( // [R7]
    en && src == 3'h6 && sel == 3'h1
    |=> PIN_TWO_OUT == $past(|({RX_PORTS_IN[3].pass, RX_PORTS_IN[2].pass,
                                RX_PORTS_IN[1].pass, RX_PORTS_IN[0].pass} & TX_SELECT_IN))
  ) else $error("Pass OR over selected ports wrong");

  a_tx_irq: assert property ( // [R8]
    en && src == 3'h6 && sel == 3'h5 |=> PIN_TWO_OUT == $past(TX_STATUS_IN.irq)
  ) else $error("Transmit interrupt not on pin");

  a_reserved_low: assert property ( // [R11]
    (src == 3'h5 || src == 3'h7 || (src == 3'h4 && sel > 3'h4)) |=> !PIN_TWO_OUT
  ) else $error("Reserved selection not driving low");

  a_group_switch: assert property ( // [R2]
    en && $changed(src) && src == 3'h6 && sel == 3'h2
    |=> PIN_TWO_OUT == $past(TX_STATUS_IN.frame_valid)
  ) else $error("Group change not followed by pin");

  a_write_answer: assert property (
    AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |=> ##1 BVALID_OUT [*1]
  ) else $error("Write answer not two cycles after address and data");

  a_read_answer: assert property (
    ARVALID_IN && ARREADY_OUT |=> RVALID_OUT && !ARREADY_OUT
  ) else $error("Read answer not one cycle after address");

endmodule

// ===== include/pin_two_pkg.sv
// Purpose: Shared constants and carrier types for the pin two output source selector
// Assumes: 32-bit AXI4-Lite register bus with 8-bit byte addresses
// Notes:   Register offsets are word indexes; the byte address is four times the index
package pin_two_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          RX_PORTS      = 4;

  // Word indexes of the registers and their byte addresses
  localparam logic [7:0]  CTRL_INDEX    = 8'h12;
  localparam logic [7:0]  STATUS_INDEX  = 8'h20;
  localparam logic [7:0]  CTRL_ADDR     = CTRL_INDEX << 2;
  localparam logic [7:0]  STATUS_ADDR   = STATUS_INDEX << 2;

  // Control register layout and reset value
  localparam int          SEL_LSB       = 5;
  localparam int          SRC_LSB       = 2;
  localparam int          VAL_BIT       = 1;
  localparam int          EN_BIT        = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Status register layout
  localparam int          STAT_DRIVE_BIT = 0;
  localparam int          STAT_LEVEL_BIT = 1;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Source group codes
  localparam logic [2:0]  SRC_DEVICE    = 3'h4;
  localparam logic [2:0]  SRC_TX        = 3'h6;

  // Signal select codes
  localparam logic [2:0]  SEL_CODE_0    = 3'h0;
  localparam logic [2:0]  SEL_CODE_1    = 3'h1;
  localparam logic [2:0]  SEL_CODE_2    = 3'h2;
  localparam logic [2:0]  SEL_CODE_3    = 3'h3;
  localparam logic [2:0]  SEL_CODE_4    = 3'h4;
  localparam logic [2:0]  SEL_CODE_5    = 3'h5;
  localparam logic [2:0]  SEL_CODE_6    = 3'h6;
  localparam logic [2:0]  SEL_CODE_7    = 3'h7;

  typedef struct packed {
    logic [2:0] signal_select;
    logic [2:0] source_group;
    logic       local_value;
    logic       drive_enable;
  } ctrl_s;

  typedef struct packed {
    logic [3:0] gpio;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } rx_port_s;

  typedef struct packed {
    logic       frame_valid;
    logic       line_valid;
    logic       synced;
    logic       irq;
  } tx_port_s;

  // An empty mask yields one, the neutral value of AND
  function automatic logic all_of(input logic [3:0] bits, input logic [3:0] mask);
    return &(bits | ~mask);
  endfunction

  function automatic logic any_of(input logic [3:0] bits, input logic [3:0] mask);
    return |(bits & mask);
  endfunction

endpackage

// ===== rtl/pin_two_source_mux.sv
// Purpose: Picks the level for pin two from the source group and signal select
// Assumes: All inputs synchronous to the device clock
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module pin_two_source_mux (
  input  wire pin_two_pkg::ctrl_s          ctrl_in,
  input  wire pin_two_pkg::rx_port_s [3:0] rx_ports_in,
  input  wire logic [3:0]                  rx_enable_in,
  input  wire logic [3:0]                  tx_select_in,
  input  wire logic                        frame_sync_in,
  input  wire pin_two_pkg::tx_port_s       tx_in,
  output logic                             level_out
);

  logic [3:0]            lock_v;
  logic [3:0]            pass_v;
  pin_two_pkg::rx_port_s port;

  always_comb begin
    lock_v = 4'h0;
    pass_v = 4'h0;
    for (int i = 0; i < pin_two_pkg::RX_PORTS; i++) begin
      lock_v[i] = rx_ports_in[i].lock;
      pass_v[i] = rx_ports_in[i].pass;
    end
  end

  always_comb begin
    level_out = 1'b0;
    port      = rx_ports_in[ctrl_in.source_group[1:0]];
    if (!ctrl_in.source_group[2]) begin // [R2]
      case (ctrl_in.signal_select)
        pin_two_pkg::SEL_CODE_4: level_out = port.lock; // [R4]
        pin_two_pkg::SEL_CODE_5: level_out = port.pass; // [R4]
        pin_two_pkg::SEL_CODE_6: level_out = port.frame_valid; // [R4]
        pin_two_pkg::SEL_CODE_7: level_out = port.line_valid; // [R4]
        default:                 level_out = port.gpio[ctrl_in.signal_select[1:0]]; // [R3]
      endcase
    end else begin
      case (ctrl_in.source_group)
        pin_two_pkg::SRC_DEVICE: begin
          case (ctrl_in.signal_select)
            pin_two_pkg::SEL_CODE_0: level_out = ctrl_in.local_value; // [R10]
            pin_two_pkg::SEL_CODE_1: level_out = pin_two_pkg::any_of(lock_v, rx_enable_in); // [R10]
            pin_two_pkg::SEL_CODE_2: level_out = pin_two_pkg::all_of(lock_v, rx_enable_in); // [R5]
            pin_two_pkg::SEL_CODE_3: level_out = pin_two_pkg::all_of(pass_v, rx_enable_in); // [R6]
            pin_two_pkg::SEL_CODE_4: level_out = frame_sync_in; // [R6]
            default:                 level_out = 1'b0; // [R11]
          endcase
        end
        pin_two_pkg::SRC_TX: begin
          case (ctrl_in.signal_select)
            pin_two_pkg::SEL_CODE_0: level_out = pin_two_pkg::all_of(pass_v, tx_select_in); // [R7]
            pin_two_pkg::SEL_CODE_1: level_out = pin_two_pkg::any_of(pass_v, tx_select_in); // [R7]
            pin_two_pkg::SEL_CODE_2: level_out = tx_in.frame_valid; // [R7]
            pin_two_pkg::SEL_CODE_3: level_out = tx_in.line_valid; // [R7]
            pin_two_pkg::SEL_CODE_4: level_out = tx_in.synced; // [R8]
            pin_two_pkg::SEL_CODE_5: level_out = tx_in.irq; // [R8]
            default:                 level_out = 1'b0; // [R11]
          endcase
        end
        default: level_out = 1'b0; // [R11]
      endcase
    end
  end

endmodule

// ===== dv/pin_two_board_model.sv
// Purpose: Board-side reader of pin two, resolving the wire level from the driver state
// Assumes: A resistor pulls the undriven wire to PULL_LEVEL
// Notes:   The bench observes the pin through this resolved level and also checks pin and drive_n directly
`timescale 1ns/1ps
module pin_two_board_model #(
  parameter logic PULL_LEVEL = 1'b0
) (
  input  wire logic pin_in,
  input  wire logic drive_n_in,
  output logic      level_out
);
  // An undriven wire shows the pull level, never the last driven value
  assign level_out = drive_n_in ? PULL_LEVEL : pin_in;
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the pin two output control register
// Assumes: AXI4-Lite master tasks; the board model resolves the pin wire
// Notes:   Expected pin levels are worked out here from the input patterns
`timescale 1ns/1ps
module tb_top;
  logic                        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]                  awaddr, araddr, ctl;
  logic [31:0]                 wdata, rdata, rd;
  logic [3:0]                  wstrb, rx_en, tx_sel;
  logic                        awready, wready, bvalid, arready, rvalid, pin, drive_n, level, fsync;
  logic [1:0]                  bresp, rresp, resp;
  pin_two_pkg::rx_port_s [3:0] rx;
  pin_two_pkg::tx_port_s       txs;
  int                          errors, n_compared;

  pin_two_output_ctrl pin_two_output_ctrl_i (
    .MCLK_IN(mclk), .RESET_IN(rst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RX_PORTS_IN(rx), .RX_ENABLE_IN(rx_en), .TX_SELECT_IN(tx_sel), .FRAME_SYNC_IN(fsync),
    .TX_STATUS_IN(txs), .PIN_TWO_OUT(pin), .PIN_TWO_DRIVE_N_OUT(drive_n));

  pin_two_board_model pin_two_board_model_i (.pin_in(pin), .drive_n_in(drive_n), .level_out(level));

  always #2 mclk = ~mclk;

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int  n;
    logic aw_done, w_done;
    aw_done = 0;
    w_done  = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (bvalid === 1'b1 && aw_done && w_done) begin
        r = bresp;
        return;
      end
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    errors++;
    close_out();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int  n;
    logic ar_done;
    ar_done = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (rvalid === 1'b1 && ar_done) begin
        d = rdata;
        r = rresp;
        return;
      end
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1;
        arvalid <= 1'b0;
      end
    end
    errors++;
    close_out();
  endtask

  // Reference selector built from the documented code tables
  function automatic logic exp_level(input logic [2:0] src, input logic [2:0] sel, input logic val);
    logic [3:0] lk, ps, st;
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx[i].lock;
      ps[i] = rx[i].pass;
    end
    st = {rx[src[1:0]].lock, rx[src[1:0]].pass, rx[src[1:0]].frame_valid, rx[src[1:0]].line_valid};
    if (src < 3'h4) begin
      return (sel < 3'h4) ? rx[src[1:0]].gpio[sel[1:0]] : st[~sel[1:0]];
    end
    if (src == 3'h4) begin
      case (sel)
        3'h0: return val;
        3'h1: return |(lk & rx_en);
        3'h2: return &(lk | ~rx_en);
        3'h3: return &(ps | ~rx_en);
        3'h4: return fsync;
        default: return 1'b0;
      endcase
    end
    if (src == 3'h6) begin
      case (sel)
        3'h0: return &(ps | ~tx_sel);
        3'h1: return |(ps & tx_sel);
        3'h2: return txs.frame_valid;
        3'h3: return txs.line_valid;
        3'h4: return txs.synced;
        3'h5: return txs.irq;
        default: return 1'b0;
      endcase
    end
    return 1'b0;
  endfunction

  initial begin
    mclk = 0; rst = 1; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h1;
    rx = 32'h0000_0000; rx_en = 4'hB; tx_sel = 4'h6; fsync = 0; txs = 4'h0;
    errors = 0; n_compared = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axi_read(pin_two_pkg::CTRL_ADDR, rd, resp);
    check(rd, 32'h0000_0000);
    axi_read(pin_two_pkg::STATUS_ADDR, rd, resp);
    check(rd, 32'h0000_0000);
    check({31'h0000_0000, drive_n}, 32'h0000_0001);
    // Unmapped places refuse and leave the control register alone
    axi_read(8'h4C, rd, resp);
    check({30'h0000_0000, resp}, {30'h0000_0000, pin_two_pkg::RESP_SLVERR});
    axi_write(8'h4C, 32'h0000_00FF, 4'h1, resp);
    check({30'h0000_0000, resp}, {30'h0000_0000, pin_two_pkg::RESP_SLVERR});
    axi_read(pin_two_pkg::CTRL_ADDR, rd, resp);
    check(rd, 32'h0000_0000);
    // Two complementary input patterns so AND and OR paths both toggle
    for (int p = 0; p < 2; p++) begin
      rx    <= p[0] ? ~32'h9A5C_36E1 : 32'h9A5C_36E1;
      // Enable masks chosen so lock and pass AND and lock OR each give both levels
      rx_en <= p[0] ? 4'h3 : 4'h2;
      fsync <= p[0];
      txs   <= p[0] ? 4'h5 : 4'hA;
      for (int c = 0; c < 64; c++) begin
        ctl = {c[5:3], c[2:0], p[0], 1'b1};
        axi_write(pin_two_pkg::CTRL_ADDR, {24'h00_0000, ctl}, 4'h1, resp);
        axi_read(pin_two_pkg::CTRL_ADDR, rd, resp);
        check(rd, {24'h00_0000, ctl});
        check({31'h0000_0000, level}, {31'h0000_0000, exp_level(c[2:0], c[5:3], p[0])});
        axi_read(pin_two_pkg::STATUS_ADDR, rd, resp);
        check(rd, {30'h0000_0000, exp_level(c[2:0], c[5:3], p[0]), 1'b1});
      end
    end
    // Driver off while the selection asks for a high frame sync
    axi_write(pin_two_pkg::CTRL_ADDR, 32'h0000_0092, 4'h1, resp);
    repeat (2) @(posedge mclk);
    check({30'h0000_0000, drive_n, pin}, 32'h0000_0002);
    check({31'h0000_0000, level}, 32'h0000_0000);
    // A write without the low byte strobe changes nothing
    axi_write(pin_two_pkg::CTRL_ADDR, 32'h0000_00FF, 4'h0, resp);
    axi_read(pin_two_pkg::CTRL_ADDR, rd, resp);
    check(rd, 32'h0000_0092);
    // Reset in mid-run clears every field again
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axi_read(pin_two_pkg::CTRL_ADDR, rd, resp);
    check(rd, 32'h0000_0000);
    check({31'h0000_0000, drive_n}, 32'h0000_0001);
    close_out();
  end
endmodule
